// ### shared/asp_pkg.sv
// Functional notes
// - mode 1: shift on rise, sample on fall
// - both selects high resets serial state, ignores clock
// - both selects high: output pin released
// - ready on pin only with converter select
// - pin shows ready unless a frame is shifting
// - continuous: ready high start, low result
// - unread result: ready pulses high 16 early
// - late read may return old or new
// - late old read delays ready fall
// - pulse mode: ready low until next start
// - status ready bit marks unread new result
// - response: status, three data bytes, check
// - status prepended only when append enabled
// - 24-bit two's complement, sign bit first
// - overdrive clips to full-scale codes
// - check bytes use polynomial 100000111b
// - first byte shifted out is 0FFh
package asp_pkg;

  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0C;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_PULSE_BIT = 1;
  localparam int CTRL_APPEND_BIT = 2;
  localparam logic CTRL_PULSE_RESET = 1'b0;
  localparam logic CTRL_APPEND_RESET = 1'b0;
  localparam logic [15:0] PERIOD_RESET = 16'h0400;

  localparam logic [7:0] MCLK_DIV = 8'h11;
  localparam logic [15:0] EARLY_LEAD = 16'h0010;

  localparam logic [7:0] FIRST_BYTE = 8'hFF;
  localparam logic [7:0] CMD_START = 8'h08;
  localparam logic [7:0] CMD_STOP = 8'h0A;
  localparam logic [7:0] CMD_RDATA = 8'h12;
  localparam logic [7:0] CMD_RREG_OP = 8'h20;
  localparam logic [7:0] CMD_OP_MASK = 8'hE0;
  localparam logic [4:0] STATUS_REG_ADDR = 5'h02;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  localparam logic [3:0] BYTE_CMD = 4'h0;
  localparam logic [3:0] BYTE_ARG = 4'h1;
  localparam logic [3:0] BYTE_CRC = 4'h2;
  localparam logic [3:0] BYTE_EXEC = 4'h3;
  localparam logic [3:0] RESP_LAST_APPEND = 4'h8;
  localparam logic [3:0] RESP_LAST_PLAIN = 4'h7;
  localparam logic [3:0] RESP_LAST_REG = 4'h5;

  localparam logic [23:0] POS_FS = 24'h7FFFFF;
  localparam logic [23:0] NEG_FS = 24'h800000;
  localparam logic signed [31:0] CLIP_HI = 32'sh007FFFFF;
  localparam logic signed [31:0] CLIP_LO = 32'shFF800000;

  localparam logic [3:0] PIN_IDLE = 4'hC;

  typedef struct packed {
    logic converter_select_n;
    logic amplifier_select_n;
    logic sclk;
    logic din;
  } asp_pins_t;

  typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_RESP, PH_DONE} asp_phase_t;

  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] r;
    r = crc ^ data;
    for (int i = 0; i < 8; i++)
    begin
      r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [23:0] clip24(input logic signed [31:0] s);
    if (s > CLIP_HI)
      return POS_FS;
    else if (s < CLIP_LO)
      return NEG_FS;
    else
      return s[23:0];
  endfunction

endpackage

// ### sim/asp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module asp_host_model
  import asp_pkg::*;
(
  output var asp_pins_t pins,
  input wire logic pin_level
);
  // --------
  // host side: mode 1, one select per frame
  // --------
  // din flips between frames so an idle sample never looks stable
  realtime half_ns = 62.5;
  logic [7:0] tx [9];
  logic [7:0] rx [9];
  initial
  begin
    pins = asp_pins_t'(PIN_IDLE);
    foreach (tx[i]) tx[i] = 8'h00;
  end
  task automatic xfer(input logic amp, input int n);
    pins.converter_select_n = amp;
    pins.amplifier_select_n = !amp;
    #(half_ns);
    for (int i = 0; i < n * 8; i++)
    begin
      pins.sclk = 1'b1;
      pins.din = tx[i / 8][7 - i % 8];
      #(half_ns);
      pins.sclk = 1'b0;
      rx[i / 8][7 - i % 8] = pin_level;
      #(half_ns);
    end
    pins.din = !pins.din;
    pins.converter_select_n = 1'b1;
    pins.amplifier_select_n = 1'b1;
    #(half_ns);
  endtask
endmodule
`default_nettype wire

// ### sim/asp_serial_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port_sva
  import asp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire asp_pins_t spi_pins,
  input wire logic serial_out_ready_n_o,
  input wire logic serial_out_ready_n_oe,
  input wire logic result_ready_n
);
  // --------
  // select history
  // --------
  // raw pins are counted, so thresholds leave room for the three-flop sync
  logic [3:0] off_reg, on_reg;
  logic seen_reg;
  wire logic conv_on = !spi_pins.converter_select_n;
  wire logic both_off = spi_pins.converter_select_n && spi_pins.amplifier_select_n;
  wire logic [3:0] off_next = !both_off ? 4'h0 : off_reg + {3'h0, off_reg != 4'hF};
  wire logic [3:0] on_next = !conv_on ? 4'h0 : on_reg + {3'h0, on_reg != 4'hF};
  wire logic seen_next = conv_on && (seen_reg || spi_pins.sclk);
  always_ff @(posedge aclk)
  begin
    off_reg <= aresetn ? off_next : 4'h0;
    on_reg <= aresetn ? on_next : 4'h0;
    seen_reg <= aresetn && seen_next;
  end
  // --------
  // properties
  // --------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_pin_released: assert property (off_reg >= 4'h8 |-> !serial_out_ready_n_oe)
    else $error("pin driven while deselected");
  a_release_soon: assert property ($rose(both_off) |-> ##[1:8] !serial_out_ready_n_oe)
    else $error("pin not released after deselect");
  a_pin_driven: assert property (on_reg >= 4'h8 |-> serial_out_ready_n_oe)
    else $error("pin released while converter selected");
  a_ready_shown: assert property (on_reg >= 4'hA && !seen_reg && $stable(result_ready_n) &&
    result_ready_n == $past(result_ready_n, 2) |-> serial_out_ready_n_o == result_ready_n)
    else $error("pin does not show ready");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while read pending");
  a_bad_addr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_RESULT
    |=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  c_ready_fall: cover property ($fell(result_ready_n));
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);
  c_ready_shown: cover property (on_reg >= 4'hA && !seen_reg);
endmodule
bind asp_serial_port asp_serial_port_sva asp_serial_port_sva_i (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .spi_pins, .serial_out_ready_n_o,
  .serial_out_ready_n_oe, .result_ready_n
);
`default_nettype wire

// ### sim/asp_serial_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port_tb
  import asp_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic signed [31:0] conv_sample = 32'sh0;
  asp_pins_t spi_pins;
  logic serial_out_ready_n_o, serial_out_ready_n_oe, result_ready_n;
  logic pin_last = 1'b1, hi_seen = 1'b0;
  logic [7:0] rx [9];
  int miscompares = 0, compares = 0, cycles = 0;
  // no keeper on the shared pin: released, it shows the inverse of its last level
  wire logic pin_level = serial_out_ready_n_oe ? serial_out_ready_n_o : !pin_last;
  asp_serial_port asp_serial_port_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .spi_pins, .serial_out_ready_n_o,
    .serial_out_ready_n_oe, .result_ready_n, .conv_sample
  );
  asp_host_model asp_host_model_i (.pins(spi_pins), .pin_level(pin_level));
  initial
  begin
    forever #4 aclk = !aclk;
  end
  always @(posedge aclk)
  begin
    cycles++;
    if (serial_out_ready_n_oe === 1'b1)
      pin_last <= serial_out_ready_n_o;
    if (!spi_pins.converter_select_n && result_ready_n === 1'b1)
      hi_seen <= 1'b1;
    if (cycles == 60000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  // --------
  // tasks
  // --------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
    input string n);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    // rready trails rvalid by one cycle so the slave must hold its answer
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1)
        s_axi_rready <= 1'b1;
    end while (s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(n, s_axi_rdata, ed);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction
  task automatic wait_rdy(input logic v);
    int n = 0;
    while (result_ready_n !== v && n < 8000)
    begin
      @(posedge aclk);
      n++;
    end
    chk("ready level", 32'(result_ready_n), 32'(v));
  endtask
  task automatic cmd(input logic amp, input logic [7:0] c, input logic bad, input int nr);
    logic [7:0] k;
    k = crc(crc(8'h00, c), 8'h00) ^ {8{bad}};
    asp_host_model_i.tx[0] = c;
    asp_host_model_i.tx[2] = k;
    hi_seen <= 1'b0;
    asp_host_model_i.xfer(amp, 4 + nr);
    rx = asp_host_model_i.rx;
    chk("first byte", 32'(rx[0]), 32'hFF);
    chk("echo", 32'(rx[1]), 32'(c));
    chk("cmd check", 32'(rx[3]), 32'(k));
  endtask
  // --------
  // sequence
  // --------
  initial
  begin
    logic [7:0] k;
    int n;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("oe idle", 32'(serial_out_ready_n_oe), 32'h0);
    rd(ADDR_CTRL, 32'h0, AXI_OKAY, "ctrl");
    rd(ADDR_PERIOD, 32'h400, AXI_OKAY, "period");
    rd(8'h10, 32'h0, AXI_SLVERR, "unmapped");
    wr(8'h10, 32'h1, AXI_SLVERR);
    wr(ADDR_RESULT, 32'h1, AXI_SLVERR);
    // short period keeps the run brief, yet three frames fit between results
    wr(ADDR_PERIOD, 32'hC8, AXI_OKAY);
    conv_sample <= 32'sh00123456;
    wr(ADDR_CTRL, 32'h5, AXI_OKAY);
    wait_rdy(1'b0);
    rd(ADDR_STATUS, 32'h2, AXI_OKAY, "status poll");
    cmd(1'b0, CMD_RDATA, 1'b0, 5);
    chk("ready in read", 32'(hi_seen), 32'h1);
    k = crc(crc(crc(crc(8'h00, 8'h01), 8'h12), 8'h34), 8'h56);
    chk("status", 32'(rx[4]), 32'h1);
    chk("result", {8'h0, rx[5], rx[6], rx[7]}, 32'h123456);
    chk("data check", 32'(rx[8]), 32'(k));
    cmd(1'b0, CMD_RREG_OP | {3'h0, STATUS_REG_ADDR}, 1'b0, 2);
    chk("status reg", 32'(rx[4]), 32'h0);
    chk("reg check", 32'(rx[5]), 32'(crc(8'h00, 8'h00)));
    cmd(1'b1, CMD_RREG_OP | 8'h10, 1'b1, 0);
    conv_sample <= 32'sh01000000;
    wait_rdy(1'b0);
    rd(ADDR_RESULT, 32'h7FFFFF, AXI_OKAY, "clip high");
    conv_sample <= 32'shFF000000;
    wait_rdy(1'b1);
    n = 0;
    while (result_ready_n === 1'b1 && n < 1000)
    begin
      @(posedge aclk);
      n++;
    end
    chk("early rise", 32'(n >= 255 && n <= 290), 32'h1);
    rd(ADDR_RESULT, 32'h800000, AXI_OKAY, "clip low");
    cmd(1'b0, CMD_STOP, 1'b0, 0);
    rd(ADDR_CTRL, 32'h4, AXI_OKAY, "stopped");
    wr(ADDR_CTRL, 32'h0, AXI_OKAY);
    wr(ADDR_CTRL, 32'h3, AXI_OKAY);
    wait_rdy(1'b1);
    wait_rdy(1'b0);
    n = 0;
    repeat (7000)
    begin
      @(posedge aclk);
      n += int'(result_ready_n !== 1'b0);
    end
    chk("pulse low", 32'(n), 32'h0);
    asp_host_model_i.half_ns = 100.0;
    cmd(1'b0, CMD_START, 1'b0, 0);
    wait_rdy(1'b1);
    wait_rdy(1'b0);
    cmd(1'b0, CMD_RDATA, 1'b0, 4);
    k = crc(crc(crc(8'h00, 8'h80), 8'h00), 8'h00);
    chk("plain result", {8'h0, rx[4], rx[5], rx[6]}, 32'h800000);
    chk("plain check", 32'(rx[7]), 32'(k));
    chk("pulse read", 32'(result_ready_n), 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire

// ### verilog/asp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module asp_pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  // a change is taken only once stages two and three agree
  wire logic [W-1:0] agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_reg <= IDLE;
      s2_reg <= IDLE;
      s3_reg <= IDLE;
      q <= IDLE;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q <= (agree & s3_reg) | (~agree & q);
    end
  end
endmodule
`default_nettype wire

// ### verilog/asp_serial_port.sv
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port
  import asp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire asp_pins_t spi_pins,
  output logic serial_out_ready_n_o,
  output logic serial_out_ready_n_oe,
  output logic result_ready_n,
  input wire logic signed [31:0] conv_sample
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  asp_pins_t pins_q;
  logic [3:0] pins_vec;

  asp_pin_sync #(.W(4), .IDLE(PIN_IDLE)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(spi_pins),
    .q(pins_vec)
  );
  assign pins_q = asp_pins_t'(pins_vec);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [AXI_ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic pulse_mode_reg;
  logic status_append_en_reg;
  logic [15:0] period_reg;

  logic [7:0] mclk_cnt_reg;
  logic mclk_en_reg;
  logic run_reg;
  logic [15:0] conv_cnt_reg;
  logic pend_reg;
  logic [23:0] pend_data_reg;
  logic [23:0] result_reg;
  logic new_flag_reg;
  logic ready_n_reg;

  asp_phase_t phase_reg;
  logic sclk_prev_reg;
  logic [2:0] bit_idx_reg;
  logic [3:0] byte_idx_reg;
  logic [6:0] rx_shift_reg;
  logic [7:0] cmd_reg;
  logic [7:0] arg_reg;
  logic [7:0] crc_in_reg;
  logic [39:0] resp_reg;
  logic [3:0] resp_last_reg;
  logic out_bit_reg;

  // ----------------------------------------
  // register bus decode
  // ----------------------------------------
  wire logic do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire logic wr_ctrl = do_write && (aw_addr_reg == ADDR_CTRL) && w_strb_reg[0];
  wire logic wr_period = do_write && (aw_addr_reg == ADDR_PERIOD);
  wire logic wr_known = (aw_addr_reg == ADDR_CTRL) || (aw_addr_reg == ADDR_PERIOD);
  wire logic rd_take = s_axi_arvalid && s_axi_arready;
  wire logic rd_known = (s_axi_araddr == ADDR_CTRL) || (s_axi_araddr == ADDR_PERIOD)
                     || (s_axi_araddr == ADDR_STATUS) || (s_axi_araddr == ADDR_RESULT);
  wire logic axi_start = wr_ctrl && w_data_reg[CTRL_RUN_BIT];
  wire logic axi_stop = wr_ctrl && !w_data_reg[CTRL_RUN_BIT];
  wire logic [7:0] status_byte = {7'h00, new_flag_reg};
  wire logic [31:0] rd_mux =
    (s_axi_araddr == ADDR_CTRL) ? {29'h0, status_append_en_reg, pulse_mode_reg, run_reg} :
    (s_axi_araddr == ADDR_PERIOD) ? {16'h0, period_reg} :
    (s_axi_araddr == ADDR_STATUS) ? {28'h0, phase_reg == PH_RESP, pend_reg,
                                     new_flag_reg, ready_n_reg} :
    (s_axi_araddr == ADDR_RESULT) ? {8'h00, result_reg} : 32'h0;
  wire logic [15:0] period_next = {w_strb_reg[1] ? w_data_reg[15:8] : period_reg[15:8],
                                   w_strb_reg[0] ? w_data_reg[7:0] : period_reg[7:0]};

  // ----------------------------------------
  // register bus slave
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ready lines fall as soon as a channel is taken and stay low until the response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !do_write;
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !do_write;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= AXI_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_known ? AXI_OKAY : AXI_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pulse_mode_reg <= CTRL_PULSE_RESET;
      status_append_en_reg <= CTRL_APPEND_RESET;
      period_reg <= PERIOD_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        pulse_mode_reg <= w_data_reg[CTRL_PULSE_BIT];
        status_append_en_reg <= w_data_reg[CTRL_APPEND_BIT];
      end
      if (wr_period)
        period_reg <= period_next;
    end
  end

  // ----------------------------------------
  // serial frame decode
  // ----------------------------------------
  wire logic sel_conv = !pins_q.converter_select_n;
  wire logic sel_amp = !pins_q.amplifier_select_n;
  wire logic sel_any = sel_conv || sel_amp;
  wire logic sclk_rise = pins_q.sclk && !sclk_prev_reg;
  wire logic sclk_fall = !pins_q.sclk && sclk_prev_reg;
  wire logic shifting = (phase_reg == PH_CMD) || (phase_reg == PH_RESP);
  wire logic [7:0] rx_byte = {rx_shift_reg, pins_q.din};
  wire logic byte_done = sclk_fall && shifting && (bit_idx_reg == 3'h7);
  wire logic [7:0] crc_cmd = crc8_byte(crc8_byte(CRC_INIT, cmd_reg), arg_reg);
  wire logic crc_ok = (crc_cmd == crc_in_reg);
  wire logic exec = byte_done && (phase_reg == PH_CMD) && (byte_idx_reg == BYTE_EXEC) && crc_ok;
  wire logic is_rdata = (cmd_reg == CMD_RDATA) && sel_conv;
  wire logic is_rreg = (cmd_reg & CMD_OP_MASK) == CMD_RREG_OP;
  wire logic snap = exec && is_rdata;
  wire logic spi_start = exec && sel_conv && (cmd_reg == CMD_START);
  wire logic spi_stop = exec && sel_conv && (cmd_reg == CMD_STOP);
  wire logic resp_end = byte_done && (phase_reg == PH_RESP) && (byte_idx_reg == resp_last_reg);
  wire logic reading = (phase_reg == PH_RESP) || snap;

  // response bytes; the check byte covers the status byte only when it is sent
  wire logic [7:0] d2 = result_reg[23:16];
  wire logic [7:0] d1 = result_reg[15:8];
  wire logic [7:0] d0 = result_reg[7:0];
  wire logic [7:0] crc3 = crc8_byte(crc8_byte(crc8_byte(CRC_INIT, d2), d1), d0);
  wire logic [7:0] crc4 = crc8_byte(crc8_byte(crc8_byte(crc8_byte(CRC_INIT, status_byte),
                                   d2), d1), d0);
  wire logic [7:0] reg_val = (cmd_reg[4:0] == STATUS_REG_ADDR) ? status_byte : 8'h00;
  wire logic [39:0] resp_next =
    !is_rdata ? {reg_val, crc8_byte(CRC_INIT, reg_val), 24'h0} :
    status_append_en_reg ? {status_byte, d2, d1, d0, crc4} :
    {d2, d1, d0, crc3, 8'h00};
  wire logic [3:0] resp_last_next = !is_rdata ? RESP_LAST_REG :
                                    status_append_en_reg ? RESP_LAST_APPEND : RESP_LAST_PLAIN;
  wire logic [3:0] resp_idx = byte_idx_reg - BYTE_EXEC - 4'h1;
  wire logic [7:0] resp_byte = resp_reg[8'(39 - 8 * resp_idx) -: 8];
  wire logic [7:0] cur_byte =
    (byte_idx_reg == BYTE_CMD) ? FIRST_BYTE :
    (byte_idx_reg == BYTE_ARG) ? cmd_reg :
    (byte_idx_reg == BYTE_CRC) ? arg_reg :
    (byte_idx_reg == BYTE_EXEC) ? (crc_ok ? crc_cmd : ~crc_cmd) : resp_byte;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sclk_prev_reg <= 1'b0;
    else
      sclk_prev_reg <= pins_q.sclk;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sel_any)
    begin
      phase_reg <= PH_IDLE;
      bit_idx_reg <= 3'h0;
      byte_idx_reg <= 4'h0;
      out_bit_reg <= 1'b1;
    end
    else
    begin
      case (phase_reg)
        PH_IDLE:
        begin
          if (sclk_rise)
          begin
            phase_reg <= PH_CMD;
            out_bit_reg <= cur_byte[3'h7 - bit_idx_reg];
          end
        end
        PH_CMD, PH_RESP:
        begin
          if (sclk_rise)
            out_bit_reg <= cur_byte[3'h7 - bit_idx_reg];
          if (sclk_fall)
            bit_idx_reg <= bit_idx_reg + 3'h1;
          if (byte_done)
            byte_idx_reg <= byte_idx_reg + 4'h1;
          if (exec)
            phase_reg <= (is_rdata || is_rreg) ? PH_RESP : PH_DONE;
          else if (byte_done && phase_reg == PH_CMD && byte_idx_reg == BYTE_EXEC)
            phase_reg <= PH_DONE;
          else if (resp_end)
            phase_reg <= PH_DONE;
        end
        PH_DONE:
          phase_reg <= PH_DONE;
        default:
          phase_reg <= PH_IDLE;
      endcase
    end
  end

  // input bits are taken on the falling edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_shift_reg <= 7'h0;
      cmd_reg <= 8'h00;
      arg_reg <= 8'h00;
      crc_in_reg <= 8'h00;
      resp_reg <= 40'h0;
      resp_last_reg <= RESP_LAST_REG;
    end
    else
    begin
      if (sclk_fall && shifting)
        rx_shift_reg <= rx_byte[6:0];
      if (byte_done && byte_idx_reg == BYTE_CMD)
        cmd_reg <= rx_byte;
      if (byte_done && byte_idx_reg == BYTE_ARG)
        arg_reg <= rx_byte;
      if (byte_done && byte_idx_reg == BYTE_CRC)
        crc_in_reg <= rx_byte;
      if (exec)
      begin
        resp_reg <= resp_next;
        resp_last_reg <= resp_last_next;
      end
    end
  end

  // ----------------------------------------
  // conversion timing and ready
  // ----------------------------------------
  wire logic start_req = axi_start || spi_start;
  wire logic stop_req = (axi_stop || spi_stop) && !start_req;
  wire logic tick = run_reg && mclk_en_reg && !start_req && !stop_req;
  wire logic complete = tick && (conv_cnt_reg == 16'h1);
  wire logic early = tick && !pulse_mode_reg && !reading
                     && (conv_cnt_reg == EARLY_LEAD + 16'h1);
  // a result finishing during a read waits, so the read keeps the old one
  wire logic commit = pend_reg && !reading;
  wire logic ready_rise = start_req || early || (snap && !pulse_mode_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || mclk_en_reg)
    begin
      mclk_cnt_reg <= 8'h1;
      mclk_en_reg <= 1'b0;
    end
    else
    begin
      mclk_cnt_reg <= mclk_cnt_reg + 8'h1;
      mclk_en_reg <= (mclk_cnt_reg == MCLK_DIV - 8'h1);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_reg <= 1'b0;
      conv_cnt_reg <= PERIOD_RESET;
    end
    else if (start_req)
    begin
      run_reg <= 1'b1;
      conv_cnt_reg <= period_reg;
    end
    else if (stop_req)
      run_reg <= 1'b0;
    else if (complete)
    begin
      run_reg <= !pulse_mode_reg;
      conv_cnt_reg <= period_reg;
    end
    else if (tick)
      conv_cnt_reg <= conv_cnt_reg - 16'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_reg <= 1'b0;
      pend_data_reg <= 24'h0;
      result_reg <= 24'h0;
      new_flag_reg <= 1'b0;
      ready_n_reg <= 1'b1;
    end
    else
    begin
      if (complete)
      begin
        pend_reg <= 1'b1;
        pend_data_reg <= clip24(conv_sample);
      end
      else if (commit || start_req)
        pend_reg <= 1'b0;
      if (commit)
        result_reg <= pend_data_reg;
      // set wins: commit is held off in the cycle a read takes its snapshot
      if (commit)
        new_flag_reg <= 1'b1;
      else if (snap)
        new_flag_reg <= 1'b0;
      if (commit && !start_req)
        ready_n_reg <= 1'b0;
      else if (ready_rise)
        ready_n_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // shared output pin
  // ----------------------------------------
  wire logic show_ready = sel_conv && !shifting;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      serial_out_ready_n_o <= 1'b1;
      serial_out_ready_n_oe <= 1'b0;
      result_ready_n <= 1'b1;
    end
    else
    begin
      serial_out_ready_n_o <= show_ready ? ready_n_reg : out_bit_reg;
      serial_out_ready_n_oe <= sel_any;
      result_ready_n <= ready_n_reg;
    end
  end

endmodule
`default_nettype wire
